// ---- deac_eeprom_ctrl.sv ----
`timescale 1ns/1ps
module deac_eeprom_ctrl
  import deac_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire deac_sfr_t  sfr,
  input  wire logic       int_ack,
  input  wire logic       stack_full,
  input  wire logic       wr_tick_async,
  output logic [7:0]      sfr_rdata,
  output logic            int_vector_req
);

  deac_regs_t q;
  deac_regs_t d;
  logic [7:0] mem_q [256];
  logic       mem_we;
  logic       ctrl_sel;
  logic       start_rd;
  logic       start_wr;
  logic       tick_rise;
  logic [7:0] ctl_rd;
  logic [7:0] intc_rd;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d         = q;
    mem_we    = 1'b0;
    start_rd  = 1'b0;
    start_wr  = 1'b0;
    // control register hides behind bank one
    ctrl_sel  = (sfr.addr == DEAC_CTRL_ADDR) && (q.bank == DEAC_CTRL_BANK);
    ctl_rd    = {4'h0, q.ctl};
    intc_rd   = {3'h0, q.mf_if, q.nvm_if, q.mf_ie, q.nvm_ie, q.gie};

    // timer ticks: three stages, level accepted when last two agree
    d.sync    = {q.sync[1:0], wr_tick_async};
    tick_rise = (q.sync[1] == q.sync[2]) && q.sync[2] && !q.tick_lvl;
    if (q.sync[1] == q.sync[2]) begin
      d.tick_lvl = q.sync[2];
    end

    if (sfr.wr) begin
      if (sfr.addr == DEAC_BANK_ADDR) begin
        d.bank = sfr.wdata[0];
      end
      if (sfr.addr == DEAC_INTC_ADDR) begin
        d.gie    = sfr.wdata[DEAC_INT_GLOBAL_EN];
        d.nvm_ie = sfr.wdata[DEAC_INT_NVM_EN];
        d.mf_ie  = sfr.wdata[DEAC_INT_MF_EN];
        d.nvm_if = sfr.wdata[DEAC_INT_NVM_FLAG];
        d.mf_if  = sfr.wdata[DEAC_INT_MF_FLAG];
      end
      if (sfr.addr == DEAC_LOC_ADDR) begin
        d.loc = sfr.wdata;
      end
      if (sfr.addr == DEAC_DATA_ADDR) begin
        d.data = sfr.wdata;
      end
      if (ctrl_sel) begin
        d.ctl[DEAC_CTL_PROG_UNLOCK]  = sfr.wdata[DEAC_CTL_PROG_UNLOCK];
        d.ctl[DEAC_CTL_FETCH_UNLOCK] = sfr.wdata[DEAC_CTL_FETCH_UNLOCK];
        // unlock must already be set: same-write unlock does not count
        if (q.state == DEAC_ST_IDLE) begin
          start_wr = sfr.wdata[DEAC_CTL_WR_START] && q.ctl[DEAC_CTL_PROG_UNLOCK];
          start_rd = sfr.wdata[DEAC_CTL_RD_START] && q.ctl[DEAC_CTL_FETCH_UNLOCK]
                     && !start_wr;
        end
      end
    end

    // service acknowledge clears only the multi-function flag
    if (int_ack) begin
      d.mf_if = 1'b0;
    end

    unique case (q.state)
      DEAC_ST_IDLE: begin
        d.cnt = 8'h00;
        if (start_wr) begin
          d.ctl[DEAC_CTL_WR_START] = 1'b1;
          d.state                  = DEAC_ST_WRITE;
        end else if (start_rd) begin
          d.ctl[DEAC_CTL_RD_START] = 1'b1;
          d.state                  = DEAC_ST_READ;
        end
      end
      DEAC_ST_READ: begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == DEAC_READ_LAST) begin
          d.data                   = mem_q[q.loc];
          d.ctl[DEAC_CTL_RD_START] = 1'b0;
          d.state                  = DEAC_ST_IDLE;
          d.cnt                    = 8'h00;
        end
      end
      DEAC_ST_WRITE: begin
        // length set by the slow timer, not by clk
        if (tick_rise) begin
          d.cnt = q.cnt + 8'h01;
          if (q.cnt == DEAC_WRITE_LAST) begin
            mem_we                   = 1'b1;
            d.ctl[DEAC_CTL_WR_START] = 1'b0;
            d.nvm_if                 = 1'b1;
            d.mf_if                  = 1'b1;
            d.state                  = DEAC_ST_IDLE;
            d.cnt                    = 8'h00;
          end
        end
      end
      default: begin
        d.state = DEAC_ST_IDLE;
      end
    endcase

    d.vec = q.gie && q.nvm_ie && q.mf_ie && q.mf_if && !stack_full;

    if (sfr.rd) begin
      if (ctrl_sel) begin
        d.rdata = ctl_rd;
      end else if (sfr.addr == DEAC_INTC_ADDR) begin
        d.rdata = intc_rd;
      end else if (sfr.addr == DEAC_LOC_ADDR) begin
        d.rdata = q.loc;
      end else if (sfr.addr == DEAC_DATA_ADDR) begin
        d.rdata = q.data;
      end else if (sfr.addr == DEAC_BANK_ADDR) begin
        d.rdata = {7'h00, q.bank};
      end else begin
        d.rdata = 8'h00;
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q.state    <= DEAC_ST_IDLE;
      q.ctl      <= DEAC_CTL_RST;
      q.loc      <= DEAC_BYTE_RST;
      q.data     <= DEAC_BYTE_RST;
      q.bank     <= DEAC_BANK_RST;
      q.gie      <= 1'b0;
      q.nvm_ie   <= 1'b0;
      q.mf_ie    <= 1'b0;
      q.nvm_if   <= 1'b0;
      q.mf_if    <= 1'b0;
      q.cnt      <= 8'h00;
      q.sync     <= 3'h0;
      q.tick_lvl <= 1'b0;
      q.rdata    <= 8'h00;
      q.vec      <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // cell array has no reset, like the real cells
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem_q[q.loc] <= q.data;
    end
  end

  assign sfr_rdata      = q.rdata;
  assign int_vector_req = q.vec;

  // ****************************************
  // checks
  // ****************************************
  property p_rd_ignored;
    @(posedge clk) disable iff (!arst_n)
      (q.state == DEAC_ST_IDLE) && sfr.wr && ctrl_sel && !q.ctl[DEAC_CTL_FETCH_UNLOCK]
      && !sfr.wdata[DEAC_CTL_WR_START] |=> !q.ctl[DEAC_CTL_RD_START];
  endproperty
  a_rd_ignored: assert property (p_rd_ignored) else $error("read began while locked");

  property p_rd_done;
    @(posedge clk) disable iff (!arst_n)
      start_rd |=> q.ctl[DEAC_CTL_RD_START] [*2] ##1 !q.ctl[DEAC_CTL_RD_START]
                   && (q.data == mem_q[$past(q.loc)]);
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read did not finish in time");

  property p_data_hold;
    @(posedge clk) disable iff (!arst_n)
      (q.state == DEAC_ST_IDLE) && !(sfr.wr && sfr.addr == DEAC_DATA_ADDR)
      |=> $stable(q.data);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data register changed idle");

  property p_wr_ignored;
    @(posedge clk) disable iff (!arst_n)
      sfr.wr && ctrl_sel && !q.ctl[DEAC_CTL_PROG_UNLOCK] && (q.state == DEAC_ST_IDLE)
      |=> (q.state != DEAC_ST_WRITE) && !q.ctl[DEAC_CTL_WR_START];
  endproperty
  a_wr_ignored: assert property (p_wr_ignored) else $error("write began while locked");

  property p_wr_end;
    @(posedge clk) disable iff (!arst_n)
      $fell(q.ctl[DEAC_CTL_WR_START]) |-> q.nvm_if && q.mf_if && (q.state == DEAC_ST_IDLE)
                                          && (mem_q[q.loc] == q.data);
  endproperty
  a_wr_end: assert property (p_wr_end) else $error("write end without flags or store");

  property p_unlock_src;
    @(posedge clk) disable iff (!arst_n)
      $rose(q.ctl[DEAC_CTL_PROG_UNLOCK]) |-> $past(sfr.wr && ctrl_sel);
  endproperty
  a_unlock_src: assert property (p_unlock_src) else $error("unlock set without write");

  property p_bank_gate;
    @(posedge clk) disable iff (!arst_n)
      sfr.wr && (sfr.addr == DEAC_CTRL_ADDR) && (q.bank != DEAC_CTRL_BANK)
      |=> $stable(q.ctl[DEAC_CTL_PROG_UNLOCK]) && $stable(q.ctl[DEAC_CTL_FETCH_UNLOCK]);
  endproperty
  a_bank_gate: assert property (p_bank_gate) else $error("control written from bank 0");

  property p_vector;
    @(posedge clk) disable iff (!arst_n)
      ##1 int_vector_req == $past(q.gie && q.nvm_ie && q.mf_ie && q.mf_if && !stack_full);
  endproperty
  a_vector: assert property (p_vector) else $error("vector request wrong");

  property p_ack_keeps;
    @(posedge clk) disable iff (!arst_n)
      int_ack && q.nvm_if && !(sfr.wr && sfr.addr == DEAC_INTC_ADDR)
      |=> q.nvm_if && (!q.mf_if || $past(q.state == DEAC_ST_WRITE));
  endproperty
  a_ack_keeps: assert property (p_ack_keeps) else $error("acknowledge cleared wrong flag");

  property p_busy_ignore;
    @(posedge clk) disable iff (!arst_n)
      (q.state != DEAC_ST_IDLE) && sfr.wr && ctrl_sel
      |=> !(q.ctl[DEAC_CTL_RD_START] && q.ctl[DEAC_CTL_WR_START])
          && ((q.state == $past(q.state)) || (q.state == DEAC_ST_IDLE));
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("start taken while busy");

  property p_upper_zero;
    @(posedge clk) disable iff (!arst_n)
      sfr.rd && ctrl_sel |=> (sfr_rdata[7:4] == 4'h0);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("control upper bits not zero");

  property p_rd_start;
    @(posedge clk) disable iff (!arst_n)
      start_rd |=> q.ctl[DEAC_CTL_RD_START] && (q.state == DEAC_ST_READ)
                   && !q.ctl[DEAC_CTL_WR_START];
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("read start not taken");

  property p_wr_start;
    @(posedge clk) disable iff (!arst_n)
      start_wr |=> q.ctl[DEAC_CTL_WR_START] && (q.state == DEAC_ST_WRITE)
                   && !q.ctl[DEAC_CTL_RD_START];
  endproperty
  a_wr_start: assert property (p_wr_start) else $error("write start not taken");

  // slow timer alone may end a write, never clk
  property p_wr_wait;
    @(posedge clk) disable iff (!arst_n)
      (q.state == DEAC_ST_WRITE) && !tick_rise
      |=> (q.state == DEAC_ST_WRITE) && q.ctl[DEAC_CTL_WR_START];
  endproperty
  a_wr_wait: assert property (p_wr_wait) else $error("write ended without tick");

  property p_tick_once;
    @(posedge clk) disable iff (!arst_n)
      tick_rise |=> !tick_rise;
  endproperty
  a_tick_once: assert property (p_tick_once) else $error("timer edge counted twice");

  // hardware set must beat a clearing write or acknowledge
  property p_flag_set_wins;
    @(posedge clk) disable iff (!arst_n)
      (q.state == DEAC_ST_WRITE) && tick_rise && (q.cnt == DEAC_WRITE_LAST)
      |=> q.nvm_if && q.mf_if && !q.ctl[DEAC_CTL_WR_START];
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins) else $error("end flags lost");

  property p_data_write;
    @(posedge clk) disable iff (!arst_n)
      sfr.wr && (sfr.addr == DEAC_DATA_ADDR) && (q.state != DEAC_ST_READ)
      |=> q.data == $past(sfr.wdata);
  endproperty
  a_data_write: assert property (p_data_write) else $error("data write lost");

endmodule // deac_eeprom_ctrl

// ---- deac_pkg.sv ----
package deac_pkg;

  // ****************************************
  // special function register map
  // ****************************************
  localparam logic [7:0] DEAC_BANK_ADDR = 8'h04;
  localparam logic [7:0] DEAC_INTC_ADDR = 8'h0E;
  localparam logic [7:0] DEAC_LOC_ADDR  = 8'h1E;
  localparam logic [7:0] DEAC_DATA_ADDR = 8'h1F;
  localparam logic [7:0] DEAC_CTRL_ADDR = 8'h40;
  localparam logic       DEAC_CTRL_BANK = 1'h1;

  // ****************************************
  // control register fields
  // ****************************************
  localparam int DEAC_CTL_PROG_UNLOCK  = 3;
  localparam int DEAC_CTL_WR_START     = 2;
  localparam int DEAC_CTL_FETCH_UNLOCK = 1;
  localparam int DEAC_CTL_RD_START     = 0;

  // ****************************************
  // interrupt control register fields
  // ****************************************
  localparam int DEAC_INT_GLOBAL_EN = 0;
  localparam int DEAC_INT_NVM_EN    = 1;
  localparam int DEAC_INT_MF_EN     = 2;
  localparam int DEAC_INT_NVM_FLAG  = 3;
  localparam int DEAC_INT_MF_FLAG   = 4;

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [3:0] DEAC_CTL_RST  = 4'h0;
  localparam logic [7:0] DEAC_BYTE_RST = 8'h00;
  localparam logic       DEAC_BANK_RST = 1'h0;
  localparam int         DEAC_CLK_MHZ       = 20;
  localparam int         DEAC_READ_TIME_NS  = 100;
  localparam int         DEAC_READ_CYCLES   = (DEAC_READ_TIME_NS * DEAC_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] DEAC_READ_LAST     = 8'(DEAC_READ_CYCLES - 1);
  localparam logic [7:0] DEAC_WRITE_TICKS   = 8'h04;
  localparam logic [7:0] DEAC_WRITE_LAST    = DEAC_WRITE_TICKS - 8'h01;

  typedef enum logic [2:0] {
    DEAC_ST_IDLE  = 3'b001,
    DEAC_ST_READ  = 3'b010,
    DEAC_ST_WRITE = 3'b100
  } deac_state_e_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } deac_sfr_t;

  typedef struct packed {
    deac_state_e_t state;
    logic [3:0]    ctl;
    logic [7:0]    loc;
    logic [7:0]    data;
    logic          bank;
    logic          gie;
    logic          nvm_ie;
    logic          mf_ie;
    logic          nvm_if;
    logic          mf_if;
    logic [7:0]    cnt;
    logic [2:0]    sync;
    logic          tick_lvl;
    logic [7:0]    rdata;
    logic          vec;
  } deac_regs_t;

endpackage

// ---- deac_tb.sv ----
`timescale 1ns/1ps
module tb;
  import deac_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic          clk;
  logic          arst_n;
  deac_sfr_t     sfr;
  logic          int_ack;
  logic          stack_full;
  logic          wr_tick_async;
  logic [7:0]    sfr_rdata;
  logic          int_vector_req;
  int            mismatches;
  int            tests_run;
  int            cycles;
  logic [7:0]    v;
  localparam int CYCLE_LIMIT = 5000;

  deac_eeprom_ctrl i_deac_eeprom_ctrl (
    .clk           (clk),
    .arst_n        (arst_n),
    .sfr           (sfr),
    .int_ack       (int_ack),
    .stack_full    (stack_full),
    .wr_tick_async (wr_tick_async),
    .sfr_rdata     (sfr_rdata),
    .int_vector_req(int_vector_req)
  );

  always #25 clk = ~clk;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic stop_test();
    $display("counts: %0d compared, %0d wrong", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard: whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == CYCLE_LIMIT) begin
      mismatches++;
      $display("wrong value at %0t: run did not finish", $time);
      stop_test();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // idle edge after each strobe so no signal is assigned twice in one step
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    sfr <= '{addr: a, wr: 1'b0, rd: 1'b0, wdata: d};
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    sfr <= '{addr: a, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
    #1;
    d = sfr_rdata;
  endtask

  // slow timer edge, held long enough for the three-flop synchroniser
  task automatic timer_tick();
    repeat (4) @(posedge clk);
    wr_tick_async <= 1'b1;
    repeat (4) @(posedge clk);
    wr_tick_async <= 1'b0;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset();
    reg_rd(DEAC_BANK_ADDR, v);
    check(v, 8'h00, "bank after reset");
    reg_wr(DEAC_CTRL_ADDR, 8'h0A);
    reg_wr(DEAC_BANK_ADDR, {7'h00, DEAC_CTRL_BANK});
    reg_rd(DEAC_CTRL_ADDR, v);
    check(v, 8'h00, "control hidden in bank 0");
    $display("test reset done");
  endtask

  task automatic test_locked_starts();
    reg_wr(DEAC_CTRL_ADDR, 8'h01);
    reg_rd(DEAC_CTRL_ADDR, v);
    check(v, 8'h00, "read start while locked");
    reg_wr(DEAC_CTRL_ADDR, 8'h04);
    reg_rd(DEAC_CTRL_ADDR, v);
    check(v, 8'h00, "write start while locked");
    reg_wr(DEAC_CTRL_ADDR, 8'h0C);
    reg_rd(DEAC_CTRL_ADDR, v);
    check(v, 8'h08, "unlock and start together");
    reg_wr(DEAC_CTRL_ADDR, 8'h00);
    $display("test locked starts done");
  endtask

  task automatic test_write();
    reg_wr(DEAC_LOC_ADDR, 8'h5A);
    reg_wr(DEAC_DATA_ADDR, 8'hA5);
    reg_wr(DEAC_INTC_ADDR, 8'h06);
    reg_wr(DEAC_CTRL_ADDR, 8'h08);
    reg_wr(DEAC_CTRL_ADDR, 8'h0C);
    reg_rd(DEAC_CTRL_ADDR, v);
    check(v, 8'h0C, "write cycle running");
    reg_wr(DEAC_CTRL_ADDR, 8'h0B);
    reg_rd(DEAC_CTRL_ADDR, v);
    check(v, 8'h0E, "start ignored mid write");
    reg_wr(DEAC_INTC_ADDR, 8'h07);
    repeat (3) timer_tick();
    repeat (8) @(posedge clk);
    reg_rd(DEAC_CTRL_ADDR, v);
    check(v, 8'h0E, "busy until last tick");
    reg_rd(DEAC_INTC_ADDR, v);
    check(v, 8'h07, "no flags before end");
    timer_tick();
    repeat (8) @(posedge clk);
    reg_rd(DEAC_CTRL_ADDR, v);
    check(v, 8'h0A, "write start cleared");
    reg_rd(DEAC_INTC_ADDR, v);
    check(v, 8'h1F, "both flags set");
    check({7'h00, int_vector_req}, 8'h01, "vector request");
    @(posedge clk);
    stack_full <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check({7'h00, int_vector_req}, 8'h00, "vector with stack full");
    @(posedge clk);
    stack_full <= 1'b0;
    int_ack    <= 1'b1;
    @(posedge clk);
    int_ack    <= 1'b0;
    reg_rd(DEAC_INTC_ADDR, v);
    check(v, 8'h0F, "service clears one flag");
    check({7'h00, int_vector_req}, 8'h00, "vector after service");
    reg_wr(DEAC_INTC_ADDR, 8'h07);
    reg_rd(DEAC_INTC_ADDR, v);
    check(v, 8'h07, "software clears nvm flag");
    $display("test write done");
  endtask

  task automatic test_read();
    int n;
    reg_wr(DEAC_DATA_ADDR, 8'h3C);
    reg_rd(DEAC_DATA_ADDR, v);
    check(v, 8'h3C, "data register");
    reg_wr(DEAC_CTRL_ADDR, 8'h0A);
    reg_wr(DEAC_LOC_ADDR, 8'h5A);
    reg_wr(DEAC_CTRL_ADDR, 8'h0B);
    n = 0;
    v = 8'h01;
    while (v[0] !== 1'b0 && n < 10) begin
      reg_rd(DEAC_CTRL_ADDR, v);
      n++;
    end
    check(v, 8'h0A, "read start cleared");
    reg_rd(DEAC_DATA_ADDR, v);
    check(v, 8'hA5, "byte fetched");
    reg_rd(DEAC_DATA_ADDR, v);
    check(v, 8'hA5, "byte kept");
    reg_wr(DEAC_CTRL_ADDR, 8'hF0);
    reg_rd(DEAC_CTRL_ADDR, v);
    check(v, 8'h00, "upper control bits");
    $display("test read done");
  endtask

  // unlock left set, then a second power-on must drop it
  task automatic test_reset_again();
    reg_wr(DEAC_CTRL_ADDR, 8'h08);
    reg_rd(DEAC_CTRL_ADDR, v);
    check(v, 8'h08, "unlock before reset");
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    reg_rd(DEAC_BANK_ADDR, v);
    check(v, 8'h00, "bank after second reset");
    reg_wr(DEAC_BANK_ADDR, {7'h00, DEAC_CTRL_BANK});
    reg_rd(DEAC_CTRL_ADDR, v);
    check(v, 8'h00, "unlock cleared by reset");
    $display("test reset again done");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    clk           = 1'b0;
    arst_n        = 1'b0;
    sfr           = '{addr: 8'h00, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
    int_ack       = 1'b0;
    stack_full    = 1'b0;
    wr_tick_async = 1'b0;
    mismatches    = 0;
    tests_run     = 0;
    cycles        = 0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    test_reset();
    test_locked_starts();
    test_write();
    test_read();
    test_reset_again();
    stop_test();
  end
endmodule // tb
